// File: verilog/osc_sel_defines.vh
// Constants for the pin-driven oscillator select block.
// Assumes inclusion by a single design file; definitions only.
`ifndef OSC_SEL_DEFINES_VH
`define OSC_SEL_DEFINES_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_PHASE_A     12'h008
`define OFS_PHASE_B     12'h00C
`define OFS_FREQ_BASE   12'h010

// ****************************************
// Control fields
// ****************************************
`define CTRL_PIN_MODE_BIT   0
`define CTRL_CPLX_MODE_BIT  1
`define CTRL_RESET          32'h0000_0000

// ****************************************
// Status fields
// ****************************************
`define STAT_SEL_A_LSB      0
`define STAT_SEL_B_LSB      2
`define STAT_CPLX_A_BIT     4
`define STAT_CPLX_B_BIT     5

`define FREQ_RESET          32'h0000_0000
`define SYNC_STAGES         2

`endif

// File: verilog/osc_pin_select.v
// Pin-driven oscillator selection for two down-converters, with APB registers.
// Assumes select pins asynchronous to pclk; APB master on pclk.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "osc_sel_defines.vh"

module osc_pin_select #(
  parameter PHASE_W = 32
) (
  // Clock and reset
  input  wire               pclk,
  input  wire               presetn,
  // APB slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [11:0]        paddr,
  input  wire [31:0]        pwdata,
  output reg  [31:0]        prdata,
  output reg                pready,
  output reg                pslverr,
  // Select pins
  input  wire               conv_a_osc_sel_lo,
  input  wire               conv_a_osc_sel_hi,
  input  wire               conv_b_osc_sel_lo,
  input  wire               conv_b_osc_sel_hi,
  // Mixer side
  output reg  [1:0]         osc_idx_a_q,
  output reg  [1:0]         osc_idx_b_q,
  output reg                mix_en_a_q,
  output reg                mix_en_b_q,
  output reg  [PHASE_W-1:0] mix_phase_a_q,
  output reg  [PHASE_W-1:0] mix_phase_b_q
);

  // ****************************************
  // Control register
  // ****************************************
  reg  [31:0]        ctrl_q;
  wire               pin_select_mode_bit = ctrl_q[`CTRL_PIN_MODE_BIT];
  wire               serial_output_mode  = ctrl_q[`CTRL_CPLX_MODE_BIT];

  // ****************************************
  // Synchronisers
  // ****************************************
  // First stage feeds only the second stage
  reg  [3:0]         sync1_q;
  reg  [3:0]         sync2_q;
  wire [3:0]         pins = {conv_b_osc_sel_hi, conv_b_osc_sel_lo,
                             conv_a_osc_sel_hi, conv_a_osc_sel_lo};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // Index latch
  // ****************************************
  // Both bits land together so the mixer never sees a half index
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_idx_a_q <= 2'h0;
      osc_idx_b_q <= 2'h0;
    end else if (pin_select_mode_bit) begin
      osc_idx_a_q <= {sync2_q[1], sync2_q[0]};
      osc_idx_b_q <= {sync2_q[3], sync2_q[2]};
    end
  end

  // ****************************************
  // Free-running oscillators
  // ****************************************
  // One accumulator per generate pass keeps a single driver per variable
  reg  [PHASE_W-1:0] freq_q  [0:7];
  wire [PHASE_W-1:0] phase_q [0:7];

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_osc
      reg  [PHASE_W-1:0] acc_q;
      assign phase_q[g] = acc_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acc_q <= {PHASE_W{1'b0}};
        end else begin
          acc_q <= acc_q + freq_q[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Mixer outputs
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mix_en_a_q    <= 1'b0;
      mix_en_b_q    <= 1'b0;
      mix_phase_a_q <= {PHASE_W{1'b0}};
      mix_phase_b_q <= {PHASE_W{1'b0}};
    end else begin
      mix_en_a_q    <= serial_output_mode;
      mix_en_b_q    <= serial_output_mode;
      mix_phase_a_q <= serial_output_mode ? phase_q[{1'b0, osc_idx_a_q}] : {PHASE_W{1'b0}};
      mix_phase_b_q <= serial_output_mode ? phase_q[{1'b1, osc_idx_b_q}] : {PHASE_W{1'b0}};
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  // Zero wait states; one access cycle per transfer
  wire               setup   = psel & ~penable;
  wire               wr_go   = psel & penable & pwrite & pready;
  // Eight frequency words from the base, one aligned word each
  wire [11:0]        foff    = paddr - `OFS_FREQ_BASE;
  wire               is_freq = (paddr[1:0] == 2'h0) && (paddr >= `OFS_FREQ_BASE) && (foff[11:5] == 7'h00);
  wire [2:0]         fidx    = foff[4:2];
  wire [PHASE_W+31:0] freq_ext = {pwdata, {PHASE_W{1'b0}}};
  wire               mapped  = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) ||
                               (paddr == `OFS_PHASE_A) || (paddr == `OFS_PHASE_B) || is_freq;
  reg  [31:0]        rd_d;

  always @* begin
    rd_d = 32'h0000_0000;
    if (paddr == `OFS_CTRL) begin
      rd_d = ctrl_q;
    end else if (paddr == `OFS_STATUS) begin
      rd_d[`STAT_SEL_A_LSB+1:`STAT_SEL_A_LSB] = osc_idx_a_q;
      rd_d[`STAT_SEL_B_LSB+1:`STAT_SEL_B_LSB] = osc_idx_b_q;
      rd_d[`STAT_CPLX_A_BIT]                  = mix_en_a_q;
      rd_d[`STAT_CPLX_B_BIT]                  = mix_en_b_q;
    end else if (paddr == `OFS_PHASE_A) begin
      rd_d = mix_phase_a_q[PHASE_W-1 -: 32];
    end else if (paddr == `OFS_PHASE_B) begin
      rd_d = mix_phase_b_q[PHASE_W-1 -: 32];
    end else if (is_freq) begin
      rd_d = freq_q[fidx][PHASE_W-1 -: 32];
    end
  end

  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `CTRL_RESET;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        freq_q[i] <= {PHASE_W{1'b0}};
      end
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata <= rd_d;
      end
      if (wr_go && paddr == `OFS_CTRL) begin
        ctrl_q <= pwdata & 32'h0000_0003;
      end
      if (wr_go && is_freq) begin
        freq_q[fidx] <= freq_ext[PHASE_W+31 -: PHASE_W];
      end
    end
  end

endmodule

// File: bench/osc_pin_host.sv
// Host model that drives the four select pins.
// Assumes pclk timing; pins move only after a rising edge.
`timescale 1ns/10ps
module osc_pin_host (
  // Clock and request
  input  wire logic       pclk,
  input  wire logic [3:0] want,
  // Select pins
  output logic            conv_a_osc_sel_lo,
  output logic            conv_a_osc_sel_hi,
  output logic            conv_b_osc_sel_lo,
  output logic            conv_b_osc_sel_hi
);
  // All four pins start low until the first rising edge
  initial {conv_b_osc_sel_hi, conv_b_osc_sel_lo, conv_a_osc_sel_hi, conv_a_osc_sel_lo} = 4'h0;
  always @(posedge pclk) begin
    {conv_b_osc_sel_hi, conv_b_osc_sel_lo, conv_a_osc_sel_hi, conv_a_osc_sel_lo} <= want;
  end
endmodule

// File: bench/osc_pin_select_assertions.sv
// Checker of the select block's ports.
// Assumes binding into osc_pin_select.
`timescale 1ns/10ps
module osc_sel_chk (
  // Clock, reset, APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and mixer
  input wire logic        conv_a_osc_sel_lo,
  input wire logic        conv_a_osc_sel_hi,
  input wire logic [1:0]  osc_idx_a_q,
  input wire logic        mix_en_a_q,
  input wire logic [31:0] mix_phase_a_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [1:0] pins_a = {conv_a_osc_sel_hi, conv_a_osc_sel_lo};
  sequence idx_held;
    $stable(osc_idx_a_q)[*2];
  endsequence
  idx_path_a: assert property ($changed(osc_idx_a_q) |-> osc_idx_a_q == $past(pins_a, 3))
    else $error("index differs from pins");
  sync_delay_a: assert property ($changed(pins_a) |=> idx_held)
    else $error("index moved too early");
  whole_update_a: assert property ($changed(osc_idx_a_q) |=> idx_held)
    else $error("index updated in parts");
  phase_gate_a: assert property (!mix_en_a_q && !$past(mix_en_a_q) |-> mix_phase_a_q == 0)
    else $error("phase not zero");
  phase_runs_a: assert property (mix_en_a_q[*3] |-> mix_phase_a_q != $past(mix_phase_a_q))
    else $error("phase stalled");
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
bind osc_pin_select osc_sel_chk u_chk (.*);

// File: bench/tb_osc_pin_select.sv
// Bench: APB access, pin selection with mode bit on and off.
// Assumes the design, the host model and the bound checker.
`timescale 1ns/10ps
module tb_osc_pin_select;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic        pready, pslverr, mix_en_a_q, mix_en_b_q;
  logic        conv_a_osc_sel_lo, conv_a_osc_sel_hi, conv_b_osc_sel_lo, conv_b_osc_sel_hi;
  logic [1:0]  osc_idx_a_q, osc_idx_b_q;
  logic [3:0]  want = '0, v;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, mix_phase_a_q, mix_phase_b_q, r, seed = 32'h0000_a45d;
  int          n_errors = 0, checks_done = 0;
  osc_pin_select DUT (.*);
  osc_pin_host u_host (.*);
  initial forever #25 pclk = ~pclk;
  function automatic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic [31:0] stat_of(input [3:0] p, input c);
    return {26'h0, c, c, p};
  endfunction
  task automatic chk(input [31:0] s, x);
    checks_done++;
    if (s !== x) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wt();
    repeat (8) @(posedge pclk);
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, '0);
    chk(r, '0);
    apb(0, 12'hffc, '0);
    chk({r[30:0], e}, 32'h0000_0001);
    for (int k = 0; k < 8; k++) apb(1, 12'(16 + 4 * k), xs() | 32'h0000_0001);
    want <= 4'hf;
    wt();
    chk(32'(osc_idx_a_q), '0);
    apb(1, 12'h000, 32'h0000_0003);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'(xs());
      want <= v;
      wt();
      chk(32'(osc_idx_a_q), 32'(v[1:0]));
      chk(32'(osc_idx_b_q), 32'(v[3:2]));
      apb(0, 12'h004, '0);
      chk(r, stat_of(v, 1));
    end
    apb(1, 12'h000, 32'h0000_0001);
    wt();
    chk(mix_phase_a_q, '0);
    chk(mix_phase_b_q, '0);
    chk(32'(mix_en_b_q), '0);
    apb(1, 12'h000, '0);
    want <= ~v;
    wt();
    chk(32'(osc_idx_a_q), 32'(v[1:0]));
    close_out();
  end
endmodule
